/* design/vfp_core.sv */
// regulator supervision: straps, reference ramp, protection latches
// assumes sensed values arrive digitised and synchronous to clk_i
//
// What this block does
// - decode boot strap into four boot voltages
// - strap ratio picks management address, resistor select picks identification address
// - on-time is ratio times resistor times 92.6ns
// - slew register at 0x1C, soft start slow
// - accept new targets up or down while running
// - live slew 7 to 38 mV/us, 32 codes
// - target from processor bus or host bus
// - alert once summed current reaches alert level
// - total overcurrent above alert level times ratio
// - total overcurrent filter, default 20us, programmable
// - total overcurrent latches off until power-on reset or enable low
// - overvoltage above reference plus programmable margin
// - overvoltage drives all phase outputs low
// - overvoltage filter 20us, cleared only by restart
// - undervoltage armed only after reaching boot voltage
// - undervoltage below reference minus margin, restart clears
// - undervoltage turns off both switches per phase
// - undervoltage filter 5us
// - per-phase overcurrent above programmable threshold
// - per-phase overcurrent floats all phase outputs
// - per-phase filter, default 6us, programmable
// - per-phase overcurrent latches off until power-on reset or enable low
// - enable low turns off, clears faults, rearms
// - phase count strapped on phase pins at reset
//
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
module vfp_core (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic por_i,
	input wire logic enable_i,
	input wire logic [7:0] boot_strap_i,
	input wire logic [7:0] addr_strap_i,
	input wire logic [2:0] addr_res_sel_i,
	input wire logic [vfp_pkg::MV_W-1:0] vout_mv_i,
	input wire logic [15:0] vin_mv_i,
	input wire logic [7:0] on_time_resistor_i,
	input wire logic cpu_vid_valid_i,
	input wire logic [vfp_pkg::MV_W-1:0] cpu_vid_mv_i,
	input wire logic [9:0] summed_phase_current_i,
	input wire logic [9:0] current_limit_alert_level_i,
	input wire logic [vfp_pkg::MV_W-1:0] feedback_sense_i,
	input wire logic [vfp_pkg::MV_W-1:0] droop_reference_node_i,
	input wire logic [4*8-1:0] phase_sense_current_i,
	input wire logic [3:0] pwm_i,
	input wire logic [3:0] pwm_in_i,
	output logic [3:0] pwm_o,
	output logic [3:0] pwm_oe_n_o,
	output logic alert_o,
	output logic [7:0] mgmt_bus_address_code_o,
	output logic [7:0] vid_bus_addr_o,
	output logic [vfp_pkg::MV_W-1:0] boot_mv_o,
	output logic [2:0] active_phases_o,
	output logic [vfp_pkg::MV_W-1:0] ref_mv_o,
	output logic [15:0] on_time_ns_o
);
	import vfp_pkg::*;

	vfp_state_t state_q;
	logic ack_q, wb_req, wr_en;
	logic [31:0] rdat_q, rd_mux;
	logic [31:0] prot_q, dly_q, slew_q;
	logic [MV_W-1:0] cmd_mv_q, ref_q, ref_d, goal;
	logic [5:0] rate;
	logic [6:0] tick_cnt_q;
	logic tick_q;
	logic [2:0] phases_q;
	logic [3:0] active;
	logic [1:0] boot_idx_q;
	logic [2:0] addr_idx;
	logic running, uv_armed, any_trip, flt_clr, pp_over;
	logic [9:0] ov_margin, uv_margin;
	logic [7:0] pp_thr;

	vfp_flt_if ocp_if ();
	vfp_flt_if pp_if ();
	vfp_flt_if ov_if ();
	vfp_flt_if uv_if ();

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : be_merge

	// wishbone slave: ack one cycle after the request, write lands on the ack edge
	assign wb_req = wb_cyc_i && wb_stb_i;
	assign wr_en = wb_req && wb_we_i && ack_q;
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_req && !ack_q;
		end
	end

	always_comb begin
		case ({wb_adr_i[7:2], 2'b00})
			OFS_TARGET: rd_mux = 32'(cmd_mv_q);
			OFS_PROT: rd_mux = prot_q;
			OFS_DELAY: rd_mux = dly_q;
			OFS_STATUS: rd_mux = {19'h0, uv_armed, alert_o, phases_q, state_q,
				uv_if.trip, ov_if.trip, pp_if.trip, ocp_if.trip};
			OFS_REF: rd_mux = 32'(ref_q);
			OFS_STRAP: rd_mux = {6'h0, boot_idx_q, vid_bus_addr_o, mgmt_bus_address_code_o, 8'h00};
			OFS_TON: rd_mux = {16'h0, on_time_ns_o};
			OFS_SLEW: rd_mux = slew_q;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_q <= 32'h0000_0000;
		end else if (wb_req && !ack_q) begin
			rdat_q <= rd_mux;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prot_q <= RST_PROT;
			dly_q <= RST_DELAY;
			slew_q <= RST_SLEW;
		end else if (wr_en) begin
			if (wb_adr_i[7:2] == OFS_PROT[7:2]) begin
				prot_q <= be_merge(prot_q, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i[7:2] == OFS_DELAY[7:2]) begin
				dly_q <= be_merge(dly_q, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i[7:2] == OFS_SLEW[7:2]) begin
				slew_q <= be_merge(slew_q, wb_dat_i, wb_sel_i) & 32'h0000_1F1F;
			end
		end
	end

	// one-microsecond tick for ramps and fault filters
	always_ff @(posedge clk_i) begin
		if (rst_i || tick_cnt_q == 7'(US_CYC - 1)) begin
			tick_cnt_q <= 7'h00;
		end else begin
			tick_cnt_q <= tick_cnt_q + 7'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= (tick_cnt_q == 7'(US_CYC - 1));
		end
	end

	// straps; phase pins are floated while reset holds so pull-ups show
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			if (!pwm_in_i[3]) begin
				phases_q <= 3'h4;
			end else if (!pwm_in_i[2]) begin
				phases_q <= 3'h3;
			end else if (!pwm_in_i[1]) begin
				phases_q <= 3'h2;
			end else begin
				phases_q <= 3'h1;
			end
		end
	end

	assign active = 4'((5'h01 << phases_q) - 5'h01);
	assign active_phases_o = phases_q;

	always_ff @(posedge clk_i) begin
		if (boot_strap_i < BOOT_TH1) begin
			boot_idx_q <= 2'h0;
		end else if (boot_strap_i < BOOT_TH2) begin
			boot_idx_q <= 2'h1;
		end else if (boot_strap_i < BOOT_TH3) begin
			boot_idx_q <= 2'h2;
		end else begin
			boot_idx_q <= 2'h3;
		end
	end

	assign boot_mv_o = BOOT_MV_TBL[boot_idx_q*MV_W +: MV_W];

	always_comb begin
		if (addr_strap_i < ADDR_BASE) begin
			addr_idx = 3'h0;
		end else if (addr_strap_i - ADDR_BASE >= 8'h80) begin
			// straps above the top step clamp to the top address
			addr_idx = 3'h7;
		end else begin
			addr_idx = 3'((addr_strap_i - ADDR_BASE) >> 4);
		end
	end

	always_ff @(posedge clk_i) begin
		mgmt_bus_address_code_o <= MGMT_ADDR_TBL[addr_idx*8 +: 8];
		if (addr_res_sel_i > 3'h4) begin
			vid_bus_addr_o <= VID_ADDR_MAX;
		end else begin
			vid_bus_addr_o <= {4'h0, addr_res_sel_i, 1'b0};
		end
	end

	// on-time = vout * r * 92.6 / vin, in ns; a zero vin saturates
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			on_time_ns_o <= 16'h0000;
		end else if (vin_mv_i == 16'h0000) begin
			on_time_ns_o <= 16'hFFFF;
		end else begin
			on_time_ns_o <= 16'((29'(vout_mv_i) * 29'(on_time_resistor_i) * 29'(TON_K_X10))
				/ (29'(vin_mv_i) * 29'(TON_DIV)));
		end
	end

	// regulation state
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i || !enable_i) begin
			state_q <= ST_OFF;
		end else begin
			case (state_q)
				ST_OFF: state_q <= ST_SOFT;
				ST_SOFT: begin
					if (any_trip) begin
						state_q <= ST_FAULT;
					end else if (ref_q == boot_mv_o) begin
						state_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (any_trip) begin
						state_q <= ST_FAULT;
					end
				end
				ST_FAULT: state_q <= ST_FAULT;
				default: state_q <= ST_OFF;
			endcase
		end
	end

	assign running = (state_q == ST_SOFT) || (state_q == ST_RUN);
	assign uv_armed = (state_q == ST_RUN);
	assign any_trip = ocp_if.trip || pp_if.trip || ov_if.trip || uv_if.trip;
	assign flt_clr = por_i || !enable_i;

	// either bus may command; the processor wins a same-cycle clash
	always_ff @(posedge clk_i) begin
		if (rst_i || state_q == ST_OFF) begin
			cmd_mv_q <= boot_mv_o;
		end else if (cpu_vid_valid_i) begin
			cmd_mv_q <= cpu_vid_mv_i;
		end else if (wr_en && wb_adr_i[7:2] == OFS_TARGET[7:2]) begin
			cmd_mv_q <= MV_W'(be_merge(32'(cmd_mv_q), wb_dat_i, wb_sel_i));
		end
	end

	// reference ramp, one rate step per microsecond
	always_comb begin
		if (state_q == ST_SOFT) begin
			rate = slew_q[SLEW_SS_LSB +: 6];
			goal = boot_mv_o;
		end else begin
			rate = LIVE_MIN_MVUS + {1'b0, slew_q[SLEW_LIVE_LSB +: 5]};
			goal = cmd_mv_q;
		end
		if (ref_q < goal) begin
			ref_d = (goal - ref_q > MV_W'(rate)) ? ref_q + MV_W'(rate) : goal;
		end else begin
			ref_d = (ref_q - goal > MV_W'(rate)) ? ref_q - MV_W'(rate) : goal;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || state_q == ST_OFF) begin
			ref_q <= '0;
		end else if (running && tick_q) begin
			ref_q <= ref_d;
		end
	end

	assign ref_mv_o = ref_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alert_o <= 1'b0;
		end else begin
			alert_o <= summed_phase_current_i >= current_limit_alert_level_i;
		end
	end

	// fault conditions; ratio is 4.4 fixed point
	assign ov_margin = MARGIN_BASE_MV + MARGIN_STEP_MV * 10'(prot_q[PROT_OV_LSB +: 2]);
	assign uv_margin = MARGIN_BASE_MV + MARGIN_STEP_MV * 10'(prot_q[PROT_UV_LSB +: 2]);
	assign pp_thr = PP_BASE_UA + PP_STEP_UA * 8'(prot_q[PROT_PP_LSB +: 2]);

	always_comb begin
		pp_over = 1'b0;
		for (int i = 0; i < NPH; i++) begin
			if (active[i] && phase_sense_current_i[i*8 +: 8] > pp_thr) begin
				pp_over = 1'b1;
			end
		end
	end

	assign ocp_if.cond = running && ({4'h0, summed_phase_current_i, 4'h0}
		> 18'(current_limit_alert_level_i) * 18'(prot_q[PROT_RATIO_LSB +: 8]));
	assign ocp_if.limit = dly_q[DLY_OCP_LSB +: 8];
	assign pp_if.cond = running && pp_over;
	assign pp_if.limit = dly_q[DLY_PP_LSB +: 8];
	assign ov_if.cond = running && ({1'b0, feedback_sense_i}
		> {1'b0, droop_reference_node_i} + 12'(ov_margin));
	assign ov_if.limit = OV_DLY_US;
	assign uv_if.cond = uv_armed && ({1'b0, feedback_sense_i} + 12'(uv_margin)
		< {1'b0, droop_reference_node_i});
	assign uv_if.limit = UV_DLY_US;

	// latches clear only on power-on reset or enable low
	vfp_persist u_ocp (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick_q), .clr_i(flt_clr),
		.fl(ocp_if));
	vfp_persist u_pp (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick_q), .clr_i(flt_clr),
		.fl(pp_if));
	vfp_persist u_ov (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick_q), .clr_i(flt_clr),
		.fl(ov_if));
	vfp_persist u_uv (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick_q), .clr_i(flt_clr),
		.fl(uv_if));

	// overvoltage pulls every phase low to crowbar; other faults float the drivers
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			pwm_o <= 4'h0;
			pwm_oe_n_o <= 4'hF;
		end else if (ov_if.trip) begin
			pwm_o <= 4'h0;
			pwm_oe_n_o <= 4'h0;
		end else if (any_trip || !running) begin
			pwm_o <= 4'h0;
			pwm_oe_n_o <= 4'hF;
		end else begin
			pwm_o <= pwm_i & active;
			pwm_oe_n_o <= ~active;
		end
	end

	property p_alert;
		@(posedge clk_i) disable iff (rst_i)
		summed_phase_current_i >= current_limit_alert_level_i |=> alert_o;
	endproperty
	a_alert: assert property (p_alert) else $error("alert missing");

	property p_ov_low;
		@(posedge clk_i) disable iff (rst_i || por_i)
		ov_if.trip |=> pwm_o == 4'h0 && pwm_oe_n_o == 4'h0;
	endproperty
	a_ov_low: assert property (p_ov_low) else $error("outputs not low on overvoltage");

	property p_float;
		@(posedge clk_i) disable iff (rst_i || por_i)
		(pp_if.trip || uv_if.trip) && !ov_if.trip |=> pwm_oe_n_o == 4'hF;
	endproperty
	a_float: assert property (p_float) else $error("outputs not floated");

	property p_ocp_hold;
		@(posedge clk_i) disable iff (rst_i)
		ocp_if.trip && enable_i && !por_i |=> ocp_if.trip && state_q != ST_RUN;
	endproperty
	a_ocp_hold: assert property (p_ocp_hold) else $error("overcurrent latch lost");

	property p_uv_arm;
		@(posedge clk_i) disable iff (rst_i)
		$rose(uv_if.trip) |-> $past(uv_armed, 2);
	endproperty
	a_uv_arm: assert property (p_uv_arm) else $error("undervoltage before arming");

	property p_disable;
		@(posedge clk_i) disable iff (rst_i)
		!enable_i |=> state_q == ST_OFF && !any_trip ##1 ref_q == '0;
	endproperty
	a_disable: assert property (p_disable) else $error("enable low did not clear");

	property p_ss_slow;
		@(posedge clk_i) disable iff (rst_i)
		state_q == ST_SOFT && tick_q |=>
			ref_q - $past(ref_q) <= MV_W'(slew_q[SLEW_SS_LSB +: 6]);
	endproperty
	a_ss_slow: assert property (p_ss_slow) else $error("soft start too fast");

	property p_phases;
		@(posedge clk_i) disable iff (rst_i)
		phases_q >= 3'h1 && phases_q <= 3'h4 && pwm_oe_n_o[0] <= pwm_oe_n_o[3];
	endproperty
	a_phases: assert property (p_phases) else $error("bad phase count");

	property p_addr;
		@(posedge clk_i) disable iff (rst_i)
		addr_strap_i >= 8'hD8 |=> mgmt_bus_address_code_o == 8'hBE;
	endproperty
	a_addr: assert property (p_addr) else $error("address strap decode wrong");
endmodule : vfp_core

/* inc/vfp_pkg.sv */
// shared constants for the regulator supervision block
// assumes a single 125 MHz clock and a byte-addressed classic Wishbone slave
package vfp_pkg;
	localparam int CLK_NS = 8;
	localparam int US_NS = 1000;
	localparam int US_CYC = US_NS / CLK_NS;
	localparam int MV_W = 11;
	localparam int NPH = 4;
	// register byte offsets
	localparam logic [7:0] OFS_TARGET = 8'h00;
	localparam logic [7:0] OFS_PROT = 8'h04;
	localparam logic [7:0] OFS_DELAY = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_REF = 8'h10;
	localparam logic [7:0] OFS_STRAP = 8'h14;
	localparam logic [7:0] OFS_TON = 8'h18;
	localparam logic [7:0] OFS_SLEW = 8'h1C;
	// reset values
	localparam logic [31:0] RST_PROT = 32'h0000_1000;
	localparam logic [31:0] RST_DELAY = 32'h0000_0614;
	localparam logic [31:0] RST_SLEW = 32'h0000_0203;
	// field positions
	localparam int PROT_OV_LSB = 0;
	localparam int PROT_UV_LSB = 2;
	localparam int PROT_PP_LSB = 4;
	localparam int PROT_RATIO_LSB = 8;
	localparam int DLY_OCP_LSB = 0;
	localparam int DLY_PP_LSB = 8;
	localparam int SLEW_LIVE_LSB = 0;
	localparam int SLEW_SS_LSB = 8;
	// filter delays in microseconds
	localparam logic [7:0] OV_DLY_US = 8'h14;
	localparam logic [7:0] UV_DLY_US = 8'h05;
	// thresholds
	localparam logic [9:0] MARGIN_BASE_MV = 10'h190;
	localparam logic [9:0] MARGIN_STEP_MV = 10'h064;
	localparam logic [7:0] PP_BASE_UA = 8'h64;
	localparam logic [7:0] PP_STEP_UA = 8'h14;
	localparam logic [5:0] LIVE_MIN_MVUS = 6'h07;
	localparam logic [9:0] TON_K_X10 = 10'h39E;
	localparam logic [3:0] TON_DIV = 4'hA;
	// strap decode, strap codes are eighth-bit fractions of supply
	localparam logic [7:0] BOOT_TH1 = 8'h0C;
	localparam logic [7:0] BOOT_TH2 = 8'h20;
	localparam logic [7:0] BOOT_TH3 = 8'h34;
	localparam logic [43:0] BOOT_MV_TBL = {11'h6D6, 11'h6A4, 11'h672, 11'h000};
	localparam logic [7:0] ADDR_BASE = 8'h60;
	localparam logic [63:0] MGMT_ADDR_TBL = 64'hBEBC_BAB8_8E8C_8A88;
	localparam logic [7:0] VID_ADDR_MAX = 8'h08;
	typedef enum logic [3:0] {
		ST_OFF = 4'b0001,
		ST_SOFT = 4'b0010,
		ST_RUN = 4'b0100,
		ST_FAULT = 4'b1000
	} vfp_state_t;
endpackage : vfp_pkg

/* inc/vfp_flt_if.sv */
// condition, limit and trip between the core and one persistence filter
// assumes the core drives cond and limit, the filter returns a latched trip
`timescale 1ns/100ps
interface vfp_flt_if;
	logic cond;
	logic [7:0] limit;
	logic trip;
	modport core (output cond, output limit, input trip);
	modport filt (input cond, input limit, output trip);
endinterface : vfp_flt_if

/* design/vfp_persist.sv */
// persistence filter: trips once cond has held for more than limit microsecond ticks, or at once for a zero limit
// assumes tick_i is a one-cycle pulse once per microsecond
`timescale 1ns/100ps
module vfp_persist (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic clr_i,
	vfp_flt_if.filt fl
);
	import vfp_pkg::*;
	logic [8:0] cnt_q;

	// resolution is one tick, so the filter may hold up to 1 us beyond its limit
	always_ff @(posedge clk_i) begin
		if (rst_i || clr_i || !fl.cond) begin
			cnt_q <= 9'h000;
		end else if (tick_i && cnt_q != 9'h1FF) begin
			cnt_q <= cnt_q + 9'h001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || clr_i) begin
			fl.trip <= 1'b0;
		// strictly above: the first tick lands anywhere in the first microsecond
		end else if (fl.cond && (cnt_q > {1'b0, fl.limit} || fl.limit == 8'h00)) begin
			fl.trip <= 1'b1;
		end
	end

	property p_trip_cause;
		@(posedge clk_i) disable iff (rst_i)
		$rose(fl.trip) |-> $past(fl.cond)
			&& ($past(cnt_q) > {1'b0, $past(fl.limit)} || $past(fl.limit) == 8'h00);
	endproperty
	a_trip_cause: assert property (p_trip_cause) else $error("trip without held cond");

	property p_trip_holds;
		@(posedge clk_i) disable iff (rst_i)
		fl.trip && !clr_i |=> fl.trip;
	endproperty
	a_trip_holds: assert property (p_trip_holds) else $error("trip dropped without clear");
endmodule : vfp_persist

/* testbench/vfp_stage_model.sv */
// gate-driver and power-stage model hanging on the four phase pins
// assumes pin data and active-low enable from the block, strap pulls from the bench
`timescale 1ns/100ps
module vfp_stage_model (
	input wire logic [3:0] pin_d_i,
	input wire logic [3:0] pin_oe_n_i,
	input wire logic [3:0] strap_pu_i,
	output logic [3:0] pin_o,
	output logic [3:0] hs_on_o,
	output logic [3:0] ls_on_o
);
	// a floated pin settles to its strap resistor, never to the last driven level
	assign pin_o = (pin_d_i & ~pin_oe_n_i) | (strap_pu_i & pin_oe_n_i);
	// a floated driver input parks both switches off
	assign hs_on_o = pin_d_i & ~pin_oe_n_i;
	assign ls_on_o = ~pin_d_i & ~pin_oe_n_i;
endmodule : vfp_stage_model

/* testbench/vfp_core_tb.sv */
// self-checking bench for the regulator supervision block
// assumes the stage model on the phase pins and a 125 MHz clock
`timescale 1ns/100ps
module vfp_core_tb;
	import vfp_pkg::*;
	localparam int LIMIT = 60000;
	localparam int T = US_CYC;
	typedef struct packed {
		logic [7:0] bs, adr;
		logic [2:0] sel;
		logic [10:0] vout;
		logic [15:0] vin;
		logic [7:0] r;
		logic [10:0] e_boot;
		logic [7:0] e_mgmt, e_vid;
		logic [15:0] e_ton;
	} vfp_row_t;
	vfp_row_t rows [8];
	logic [3:0] pu_tbl [4] = '{4'h0, 4'hC, 4'hE, 4'h8};
	logic [2:0] ph_tbl [4] = '{3'h4, 3'h2, 3'h1, 3'h3};
	logic clk_i = 1'b0;
	logic rst_i, wb_cyc_i, wb_stb_i, wb_we_i, por_i, enable_i, cpu_vid_valid_i;
	logic wb_ack_o, alert_o;
	logic [7:0] wb_adr_i, boot_strap_i, addr_strap_i, on_time_resistor_i;
	logic [7:0] mgmt_bus_address_code_o, vid_bus_addr_o;
	logic [3:0] wb_sel_i, pwm_i, pwm_in_i, pwm_o, pwm_oe_n_o, strap_pu, hs_on, ls_on;
	logic [31:0] wb_dat_i, wb_dat_o, phase_sense_current_i, q;
	logic [MV_W-1:0] vout_mv_i, cpu_vid_mv_i, feedback_sense_i, droop_reference_node_i;
	logic [MV_W-1:0] boot_mv_o, ref_mv_o;
	logic [15:0] vin_mv_i, on_time_ns_o;
	logic [9:0] summed_phase_current_i, current_limit_alert_level_i;
	logic [2:0] addr_res_sel_i, active_phases_o;
	int errors = 0;
	int n_compared = 0;
	int cyc_cnt = 0;
	int n;

	vfp_core dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .por_i, .enable_i, .boot_strap_i, .addr_strap_i,
		.addr_res_sel_i, .vout_mv_i, .vin_mv_i, .on_time_resistor_i, .cpu_vid_valid_i,
		.cpu_vid_mv_i, .summed_phase_current_i, .current_limit_alert_level_i,
		.feedback_sense_i, .droop_reference_node_i, .phase_sense_current_i, .pwm_i,
		.pwm_in_i, .pwm_o, .pwm_oe_n_o, .alert_o, .mgmt_bus_address_code_o,
		.vid_bus_addr_o, .boot_mv_o, .active_phases_o, .ref_mv_o, .on_time_ns_o);
	vfp_stage_model stage (.pin_d_i(pwm_o), .pin_oe_n_i(pwm_oe_n_o), .strap_pu_i(strap_pu),
		.pin_o(pwm_in_i), .hs_on_o(hs_on), .ls_on_o(ls_on));

	always #(CLK_NS / 2) clk_i = ~clk_i;

	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == LIMIT) begin
			errors++;
			test_done();
		end
	end

	task automatic test_done();
		if (errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// one classic cycle; read data lands in q at the ack edge
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		// no local limit: a missing ack ends in the bench timeout
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	// counts cycles in n until a pin or the reference shows exp, or lim runs out
	task automatic wait_on(input int w, input logic [15:0] exp, input int lim);
		logic [15:0] v;
		n = 0;
		forever begin
			case (w)
				0: v = {12'h000, pwm_o};
				1: v = {12'h000, pwm_oe_n_o};
				default: v = {5'h00, ref_mv_o};
			endcase
			if (v === exp || n >= lim)
				break;
			@(posedge clk_i);
			n++;
		end
	endtask : wait_on

	task automatic flags(input string what, input logic [3:0] exp);
		wb(1'b0, OFS_STATUS, 32'h0);
		chk(what, 32'(q[3:0]), 32'(exp));
	endtask : flags

	// off, back on, then poll until the state reads running
	task automatic restart();
		int k;
		k = 0;
		enable_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		enable_i <= 1'b1;
		do begin
			wb(1'b0, OFS_STATUS, 32'h0);
			k++;
		end while (q[7:4] !== 4'h4 && k < 5000);
	endtask : restart

	initial begin
		rows[0] = '{8'h00, 8'h68, 3'h0, 11'h6A4, 16'h2EE0, 8'h24, 11'h000, 8'h88, 8'h00, 16'h01D8};
		rows[1] = '{8'h18, 8'h78, 3'h1, 11'h3E8, 16'h03E8, 8'h0A, 11'h672, 8'h8A, 8'h02, 16'h039E};
		rows[2] = '{8'h28, 8'h88, 3'h2, 11'h1F4, 16'h07D0, 8'h28, 11'h6A4, 8'h8C, 8'h04, 16'h039E};
		rows[3] = '{8'h40, 8'h98, 3'h3, 11'h4B0, 16'h2EE0, 8'h64, 11'h6D6, 8'h8E, 8'h06, 16'h039E};
		rows[4] = '{8'h00, 8'hA8, 3'h4, 11'h3E8, 16'h0000, 8'h0A, 11'h000, 8'hB8, 8'h08, 16'hFFFF};
		rows[5] = '{8'h18, 8'hB8, 3'h5, 11'h44C, 16'h2EE0, 8'h18, 11'h672, 8'hBA, 8'h08, 16'h00CB};
		rows[6] = '{8'h28, 8'hC8, 3'h6, 11'h320, 16'h2EE0, 8'h35, 11'h6A4, 8'hBC, 8'h08, 16'h0147};
		rows[7] = '{8'h40, 8'hD8, 3'h7, 11'h708, 16'h2EE0, 8'h12, 11'h6D6, 8'hBE, 8'h08, 16'h00FA};
		{wb_cyc_i, wb_stb_i, wb_we_i, por_i, enable_i, cpu_vid_valid_i} = '0;
		{wb_adr_i, boot_strap_i, addr_strap_i, on_time_resistor_i, addr_res_sel_i} = '0;
		{wb_sel_i, wb_dat_i, phase_sense_current_i, vout_mv_i, cpu_vid_mv_i, vin_mv_i} = '0;
		{summed_phase_current_i, strap_pu} = '0;
		pwm_i = 4'hF;
		feedback_sense_i = 11'h3E8;
		droop_reference_node_i = 11'h3E8;
		current_limit_alert_level_i = 10'h064;
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("float", 32'(pwm_oe_n_o), 32'hF);
		wb(1'b0, OFS_PROT, 32'h0);
		chk("prot", q, RST_PROT);
		wb(1'b0, OFS_DELAY, 32'h0);
		chk("delay", q, RST_DELAY);
		wb(1'b0, OFS_SLEW, 32'h0);
		chk("slew", q, RST_SLEW);
		wb(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
		wb(1'b0, OFS_STATUS, 32'h0);
		chk("status", q, 32'h0000_0410);
		wb(1'b1, 8'h20, 32'h1234_5678);
		wb(1'b0, 8'h20, 32'h0);
		chk("unmapped", q, 32'h0);
		for (int i = 0; i < 8; i++) begin
			boot_strap_i <= rows[i].bs;
			addr_strap_i <= rows[i].adr;
			addr_res_sel_i <= rows[i].sel;
			vout_mv_i <= rows[i].vout;
			vin_mv_i <= rows[i].vin;
			on_time_resistor_i <= rows[i].r;
			repeat (4) @(posedge clk_i);
			chk("boot", 32'(boot_mv_o), 32'(rows[i].e_boot));
			chk("mgmt", 32'(mgmt_bus_address_code_o), 32'(rows[i].e_mgmt));
			chk("vid", 32'(vid_bus_addr_o), 32'(rows[i].e_vid));
			chk("ton", 32'(on_time_ns_o), 32'(rows[i].e_ton));
		end
		for (int i = 0; i < 4; i++) begin
			strap_pu <= pu_tbl[i];
			por_i <= 1'b1;
			repeat (2) @(posedge clk_i);
			por_i <= 1'b0;
			@(posedge clk_i);
			chk("phases", 32'(active_phases_o), 32'(ph_tbl[i]));
		end
		// slow soft-start rate raised so the ramp fits the run
		boot_strap_i <= 8'h18;
		wb(1'b1, OFS_SLEW, 32'h0000_1F00);
		wb(1'b1, OFS_TARGET, 32'h0000_0672);
		enable_i <= 1'b1;
		wait_on(2, 16'h0672, 60 * T);
		chk("soft ramp", 32'(n >= 53 * T && n <= 55 * T + 5), 32'h1);
		wb(1'b0, OFS_STATUS, 32'h0);
		chk("run armed", 32'({q[12], q[7:4]}), 32'h14);
		wb(1'b1, OFS_TARGET, 32'h0000_06D6);
		wait_on(2, 16'h06D6, 20 * T);
		chk("up slew", 32'(n >= 14 * T - 5 && n <= 15 * T + 10), 32'h1);
		wb(1'b1, OFS_SLEW, 32'h0000_1F1F);
		cpu_vid_mv_i <= 11'h640;
		cpu_vid_valid_i <= 1'b1;
		@(posedge clk_i);
		cpu_vid_valid_i <= 1'b0;
		wait_on(2, 16'h0640, 10 * T);
		chk("down slew", 32'(n >= 3 * T - 5 && n <= 4 * T + 10), 32'h1);
		wb(1'b0, OFS_TARGET, 32'h0);
		chk("target", q, 32'h0000_0640);
		summed_phase_current_i <= 10'h063;
		repeat (3) @(posedge clk_i);
		chk("alert low", 32'(alert_o), 32'h0);
		summed_phase_current_i <= 10'h064;
		repeat (3) @(posedge clk_i);
		chk("alert high", 32'(alert_o), 32'h1);
		summed_phase_current_i <= 10'h000;
		// three phases: the unused fourth phase must not trip
		wb(1'b1, OFS_DELAY, 32'h0000_0114);
		phase_sense_current_i <= 32'hC864_0000;
		wait_on(1, 16'h000F, 3 * T);
		chk("pp idle", n, 3 * T);
		phase_sense_current_i <= 32'hC865_0000;
		wait_on(1, 16'h000F, 3 * T);
		chk("pp delay", 32'(n >= T && n <= 2 * T + 5), 32'h1);
		chk("pp gates", 32'({hs_on, ls_on}), 32'h0);
		phase_sense_current_i <= 32'h0;
		repeat (10) @(posedge clk_i);
		chk("pp latch", 32'(pwm_oe_n_o), 32'hF);
		flags("pp flag", 4'h2);
		restart();
		flags("en clear", 4'h0);
		wb(1'b1, OFS_PROT, 32'h0000_1001);
		feedback_sense_i <= 11'h5DC;
		wait_on(0, 16'h0000, 22 * T);
		chk("ov idle", n, 22 * T);
		feedback_sense_i <= 11'h5DD;
		wait_on(0, 16'h0000, 23 * T);
		chk("ov delay", 32'(n >= 20 * T && n <= 21 * T + 5), 32'h1);
		chk("ov gates", 32'({hs_on, ls_on}), 32'h0F);
		feedback_sense_i <= 11'h3E8;
		repeat (10) @(posedge clk_i);
		chk("ov latch", 32'({pwm_o, pwm_oe_n_o}), 32'h0);
		flags("ov flag", 4'h4);
		restart();
		feedback_sense_i <= 11'h257;
		wait_on(1, 16'h000F, 7 * T);
		chk("uv delay", 32'(n >= 5 * T && n <= 6 * T + 5), 32'h1);
		chk("uv gates", 32'({hs_on, ls_on}), 32'h0);
		feedback_sense_i <= 11'h3E8;
		flags("uv flag", 4'h8);
		restart();
		wb(1'b1, OFS_PROT, 32'h0000_2000);
		wb(1'b1, OFS_DELAY, 32'h0000_0600);
		summed_phase_current_i <= 10'h0C8;
		repeat (6) @(posedge clk_i);
		// three phases strapped: the fourth stays floated while running
		chk("ocp idle", 32'(pwm_oe_n_o), 32'h8);
		summed_phase_current_i <= 10'h0C9;
		wait_on(1, 16'h000F, 6);
		chk("ocp trip", 32'(n <= 4), 32'h1);
		flags("ocp flag", 4'h1);
		summed_phase_current_i <= 10'h000;
		por_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		por_i <= 1'b0;
		@(posedge clk_i);
		flags("por clear", 4'h0);
		test_done();
	end
endmodule : vfp_core_tb
